// file: pms_params.svh
// offsets, field positions, reset values and counts for the protection/maintenance block
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// register byte offsets
`define PMS_OFS_WORD      8'h00
`define PMS_OFS_CFG       8'h04
`define PMS_OFS_CMD       8'h08
`define PMS_OFS_STATUS    8'h0C
`define PMS_OFS_IRQ_STAT  8'h10
`define PMS_OFS_IRQ_MASK  8'h14
`define PMS_OFS_CAP_MEAS  8'h18
`define PMS_OFS_CAP_LIMIT 8'h1C

// selection word bit positions
`define PMS_BIT_CARRIER   0
`define PMS_BIT_IN_PHASE  1
`define PMS_BIT_OUT_PHASE 2
`define PMS_BIT_CAP_USER  3
`define PMS_BIT_CAP_JUDGE 4
`define PMS_BIT_FAN_CONT  5

// command register bit
`define PMS_CMD_TRIP_CLR  0

// reset values and factory capacitor-life limit
`define PMS_WORD_RST      6'h00
`define PMS_CAP_LIMIT_RST 16'h0000
`define PMS_CAP_FACTORY   16'h1000

// interrupt event positions
`define PMS_EV_THERMAL    0
`define PMS_EV_IN_PHASE   1
`define PMS_EV_OUT_PHASE  2
`define PMS_EV_FAN        3
`define PMS_EV_CAP_LIFE   4
`define PMS_EV_CARRIER    5

`endif

// file: pms_pkg.sv
// types shared by the protection/maintenance block
package pms_pkg;
  typedef logic [5:0]  pms_word_t;
  typedef logic [15:0] pms_count_t;
  typedef enum {PMS_CAP_IDLE, PMS_CAP_COUNT, PMS_CAP_DONE} pms_cap_e;
endpackage

// file: pms_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pms_sync3
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // shift chain; stage1 only feeds stage2
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else if (clk_en)
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // each bit follows once the second and third stages agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_b)
      begin
        if (!rst_b)
          sync_out[gi] <= 1'b0;
        else if (clk_en && (stage2[gi] == stage3[gi]))
          sync_out[gi] <= stage3[gi];
      end
    end
  endgenerate

endmodule

// file: pms_top.sv
// protection and maintenance selection logic with apb registers
`timescale 1ns/1ps
`include "pms_params.svh"

// What this block does
// - bit0 set: overheat or overload lowers carrier instead of tripping.
// - bit1 set: supply phase loss or imbalance stops drive, raises alarm.
// - bit2 set: lost output phase while running stops drive, raises alarm.
// - bit3 picks capacitor-life limit: factory default or user value.
// - bit4 set: time bus discharge after power-off to judge capacitor life.
// - fan lock with bit5 clear alarms and coasts; bit5 set keeps running.
// - fan lock raises overheat and life-warning status outputs whatever bit5 selects.
// - fan control on: commanded fan stop hides lock; start runs fan in the same cycle as the motor.
module pms_top
  import pms_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        heatsink_overheat,
  input  wire logic        overload_detect,
  input  wire logic        input_phase_fault,
  input  wire logic        output_phase_fault,
  input  wire logic        fan_lock_detect,
  input  wire logic        power_off,
  input  wire logic        bus_discharged,
  input  wire logic        run_request,
  input  wire logic        trip_reset_pin,
  output logic             motor_run,
  output logic             motor_coast,
  output logic             carrier_lower,
  output logic             overheat_status_output,
  output logic             life_warning,
  output logic             fan_run_cmd,
  output logic             alarm_thermal,
  output logic             alarm_in_phase,
  output logic             alarm_out_phase,
  output logic             alarm_fan,
  output logic             irq
);

  pms_word_t   protection_maint_word;
  pms_count_t  cap_limit_user, cap_meas, cap_count, cap_limit;
  pms_cap_e    cap_state;
  logic [5:0]  irq_stat, irq_mask, events;
  logic [6:0]  pin_sync;
  logic [31:0] next_rdata;
  logic        fan_onoff_control, cap_life_reached, power_off_d, carrier_lower_d, cap_life_d;
  logic        s_overheat, s_overload, s_in_phase, s_out_phase, s_fan_lock, s_power_off, s_discharged;
  logic        stress, fan_lock_eff, trip_any, trip_clear, wr_en, rd_done, addr_ok;

  // pins from the power stage and fan cross into ref_clk
  pms_sync3 #(.WIDTH(7)) u_sync
  (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in ({bus_discharged, power_off, fan_lock_detect, output_phase_fault,
                input_phase_fault, overload_detect, heatsink_overheat}),
    .sync_out (pin_sync)
  );

  // filtered pins, unpacked in the order they went in
  assign {s_discharged, s_power_off, s_fan_lock, s_out_phase, s_in_phase, s_overload, s_overheat} = pin_sync;

  // apb decode; one setup cycle, one access cycle
  assign wr_en   = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;
  assign addr_ok = (paddr == `PMS_OFS_WORD) || (paddr == `PMS_OFS_CFG) || (paddr == `PMS_OFS_CMD) ||
                   (paddr == `PMS_OFS_STATUS) || (paddr == `PMS_OFS_IRQ_STAT) ||
                   (paddr == `PMS_OFS_IRQ_MASK) || (paddr == `PMS_OFS_CAP_MEAS) ||
                   (paddr == `PMS_OFS_CAP_LIMIT);

  // fan stopped on purpose under on/off control does not count as locked
  assign fan_lock_eff = s_fan_lock && !(fan_onoff_control && !fan_run_cmd);
  assign stress       = s_overheat || s_overload;
  assign trip_any     = alarm_thermal || alarm_in_phase || alarm_out_phase || alarm_fan;
  assign trip_clear   = trip_reset_pin || (wr_en && (paddr == `PMS_OFS_CMD) && pwdata[`PMS_CMD_TRIP_CLR]);
  assign cap_limit    = protection_maint_word[`PMS_BIT_CAP_USER] ? cap_limit_user : `PMS_CAP_FACTORY;

  // ready and error answer in the access cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  // read data mux, captured in the setup cycle
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      `PMS_OFS_WORD:      next_rdata = {26'h000_0000, protection_maint_word};
      `PMS_OFS_CFG:       next_rdata = {31'h0000_0000, fan_onoff_control};
      `PMS_OFS_STATUS:    next_rdata = {21'h00_0000, cap_life_reached, fan_run_cmd, life_warning,
                                        overheat_status_output, carrier_lower, motor_coast, motor_run,
                                        alarm_fan, alarm_out_phase, alarm_in_phase, alarm_thermal};
      `PMS_OFS_IRQ_STAT:  next_rdata = {26'h000_0000, irq_stat};
      `PMS_OFS_IRQ_MASK:  next_rdata = {26'h000_0000, irq_mask};
      `PMS_OFS_CAP_MEAS:  next_rdata = {16'h0000, cap_meas};
      `PMS_OFS_CAP_LIMIT: next_rdata = {16'h0000, cap_limit_user};
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable)
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
  end

  // writable configuration registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      protection_maint_word <= `PMS_WORD_RST;
      fan_onoff_control     <= 1'b0;
      cap_limit_user        <= `PMS_CAP_LIMIT_RST;
      irq_mask              <= 6'h00;
    end
    else if (clk_en && wr_en)
    begin
      case (paddr)
        `PMS_OFS_WORD:      protection_maint_word <= pwdata[5:0];
        `PMS_OFS_CFG:       fan_onoff_control     <= pwdata[0];
        `PMS_OFS_CAP_LIMIT: cap_limit_user        <= pwdata[15:0];
        `PMS_OFS_IRQ_MASK:  irq_mask              <= pwdata[5:0];
        default:            ;
      endcase
    end
  end

  // thermal trip only when carrier lowering is off; latched until cleared
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_thermal <= 1'b0;
    else if (clk_en)
    begin
      if (stress && !protection_maint_word[`PMS_BIT_CARRIER])
        alarm_thermal <= 1'b1;
      else if (trip_clear)
        alarm_thermal <= 1'b0;
    end
  end

  // carrier lowering replaces the thermal trip
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      carrier_lower <= 1'b0;
    else if (clk_en)
      carrier_lower <= stress && protection_maint_word[`PMS_BIT_CARRIER];
  end

  // input phase loss trip
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_in_phase <= 1'b0;
    else if (clk_en)
    begin
      if (s_in_phase && protection_maint_word[`PMS_BIT_IN_PHASE])
        alarm_in_phase <= 1'b1;
      else if (trip_clear)
        alarm_in_phase <= 1'b0;
    end
  end

  // output phase loss trip, only while the motor runs
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_out_phase <= 1'b0;
    else if (clk_en)
    begin
      if (s_out_phase && motor_run && protection_maint_word[`PMS_BIT_OUT_PHASE])
        alarm_out_phase <= 1'b1;
      else if (trip_clear)
        alarm_out_phase <= 1'b0;
    end
  end

  // fan lock alarm unless continue-operation is chosen
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      alarm_fan <= 1'b0;
    else if (clk_en)
    begin
      if (fan_lock_eff && !protection_maint_word[`PMS_BIT_FAN_CONT])
        alarm_fan <= 1'b1;
      else if (trip_clear || (fan_onoff_control && !fan_run_cmd))
        alarm_fan <= 1'b0;
    end
  end

  // motor run follows the latched trips, coast follows the fan alarm only
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      motor_run   <= 1'b0;
      motor_coast <= 1'b0;
    end
    else if (clk_en)
    begin
      motor_run   <= run_request && !trip_any;
      motor_coast <= alarm_fan;
    end
  end

  // fan command: always on unless on/off control, then on with a start
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      fan_run_cmd <= 1'b0;
    else if (clk_en)
      fan_run_cmd <= !fan_onoff_control || run_request;
  end

  // status outputs on fan lock, whatever bit5 selects
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overheat_status_output <= 1'b0;
      life_warning           <= 1'b0;
    end
    else if (clk_en)
    begin
      overheat_status_output <= fan_lock_eff;
      life_warning           <= fan_lock_eff || cap_life_reached;
    end
  end

  // capacitor discharge timer started at power-off
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cap_state        <= PMS_CAP_IDLE;
      cap_count        <= 16'h0000;
      cap_meas         <= 16'h0000;
      cap_life_reached <= 1'b0;
      power_off_d      <= 1'b0;
    end
    else if (clk_en)
    begin
      power_off_d <= s_power_off;
      case (cap_state)
        PMS_CAP_IDLE:
        begin
          if (s_power_off && !power_off_d && protection_maint_word[`PMS_BIT_CAP_JUDGE])
          begin
            cap_count <= 16'h0000;
            cap_state <= PMS_CAP_COUNT;
          end
        end
        PMS_CAP_COUNT:
        begin
          if (!protection_maint_word[`PMS_BIT_CAP_JUDGE])
            cap_state <= PMS_CAP_IDLE; // judgment suppressed mid-run
          else if (s_discharged)
          begin
            cap_meas         <= cap_count;
            cap_life_reached <= cap_count < cap_limit;
            cap_state        <= PMS_CAP_DONE;
          end
          else if (cap_count != 16'hFFFF)
            cap_count <= cap_count + 16'h0001;
        end
        PMS_CAP_DONE:
          if (!s_power_off)
            cap_state <= PMS_CAP_IDLE;
        default:
          cap_state <= PMS_CAP_IDLE;
      endcase
    end
  end

  // one-cycle event terms for the interrupt status
  assign events[`PMS_EV_THERMAL]   = stress && !protection_maint_word[`PMS_BIT_CARRIER] && !alarm_thermal;
  assign events[`PMS_EV_IN_PHASE]  = s_in_phase && protection_maint_word[`PMS_BIT_IN_PHASE] && !alarm_in_phase;
  assign events[`PMS_EV_OUT_PHASE] = s_out_phase && motor_run && protection_maint_word[`PMS_BIT_OUT_PHASE] &&
                                     !alarm_out_phase;
  assign events[`PMS_EV_FAN]       = fan_lock_eff && !overheat_status_output;
  assign events[`PMS_EV_CAP_LIFE]  = cap_life_reached && !cap_life_d;
  assign events[`PMS_EV_CARRIER]   = carrier_lower && !carrier_lower_d;

  // sticky status, cleared by reading it; a new event wins over the clear
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_stat        <= 6'h00;
      irq             <= 1'b0;
      carrier_lower_d <= 1'b0;
      cap_life_d      <= 1'b0;
    end
    else if (clk_en)
    begin
      carrier_lower_d <= carrier_lower; // edge history for the event terms
      cap_life_d      <= cap_life_reached;
      irq             <= |(irq_stat & irq_mask);
      if (rd_done && (paddr == `PMS_OFS_IRQ_STAT))
        irq_stat <= events;
      else
        irq_stat <= irq_stat | events;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  carrier_instead_a: assert property (clk_en && stress && protection_maint_word[0] |=> carrier_lower)
    else $error("carrier not lowered under stress");
  thermal_trip_a: assert property (clk_en && stress && !protection_maint_word[0] |=> alarm_thermal)
    else $error("thermal trip missing");
  in_phase_trip_a: assert property (clk_en && s_in_phase && protection_maint_word[1] |=> alarm_in_phase)
    else $error("input phase trip missing");
  in_phase_off_a: assert property (!protection_maint_word[1] && !alarm_in_phase |=> !alarm_in_phase)
    else $error("input phase trip while disabled");
  out_phase_trip_a: assert property (clk_en && s_out_phase && motor_run && protection_maint_word[2]
                                     |=> alarm_out_phase)
    else $error("output phase trip missing");
  cap_limit_sel_a: assert property (cap_limit == (protection_maint_word[3] ? cap_limit_user : 16'h1000))
    else $error("capacitor limit source wrong");
  cap_suppress_a: assert property (cap_state == PMS_CAP_IDLE && !protection_maint_word[4]
                                   |=> cap_state == PMS_CAP_IDLE)
    else $error("capacitor judged while disabled");
  fan_continue_a: assert property (protection_maint_word[5] && !alarm_fan |=> !alarm_fan)
    else $error("fan alarm despite continue");
  fan_status_a: assert property (clk_en && fan_lock_eff |=> overheat_status_output && life_warning)
    else $error("fan lock status outputs missing");
  fan_cmd_a: assert property (clk_en && run_request |=> fan_run_cmd)
    else $error("fan not commanded on start");
  trip_stops_a: assert property (clk_en && trip_any |=> !motor_run)
    else $error("motor runs while tripped");
  trip_hold_a: assert property (alarm_in_phase && !trip_clear |=> alarm_in_phase)
    else $error("trip dropped without reset");

  thermal_cover_c: cover property (stress ##1 alarm_thermal ##[1:8] trip_clear);
  fan_lock_cover_c: cover property (fan_lock_eff ##1 alarm_fan && motor_coast);
  cap_judge_cover_c: cover property (cap_state == PMS_CAP_COUNT ##[1:100] cap_state == PMS_CAP_DONE);

endmodule

// file: pms_plant.sv
// behavioural model of the drive power stage, cooling fan and dc bus
`timescale 1ns/1ps
module pms_plant
(
  input  wire logic        ref_clk,
  input  wire logic        motor_run,
  input  wire logic        fan_run_cmd,
  input  wire logic [1:0]  stress,
  input  wire logic        in_loss,
  input  wire logic        out_loss,
  input  wire logic        fan_locked,
  input  wire logic        cap_go,
  input  wire logic [15:0] cap_len,
  output logic             heatsink_overheat,
  output logic             overload_detect,
  output logic             input_phase_fault,
  output logic             output_phase_fault,
  output logic             fan_lock_detect,
  output logic             power_off,
  output logic             bus_discharged
);
  logic [15:0] cap_cnt;
  logic        cap_busy;

  // quiet plant at time zero
  initial
  begin
    {heatsink_overheat, overload_detect, input_phase_fault, output_phase_fault} = 4'h0;
    {fan_lock_detect, power_off, bus_discharged, cap_busy} = 4'h0;
    cap_cnt = 16'h0000;
  end

  // fault pins follow the physical state of the plant
  always @(posedge ref_clk)
  begin
    heatsink_overheat  <= stress[0];
    overload_detect    <= stress[1];
    input_phase_fault  <= in_loss;
    output_phase_fault <= out_loss & motor_run;     // a lost output phase only shows while running
    fan_lock_detect    <= fan_locked & fan_run_cmd; // (a stopped fan cannot be seen locked)
  end

  // power-off, bus discharged after cap_len cycles, then power returns
  always @(posedge ref_clk)
  begin
    if (cap_go)
    begin
      cap_busy       <= 1'b1;
      cap_cnt        <= 16'h0000;
      power_off      <= 1'b1;
      bus_discharged <= 1'b0;
    end
    else if (cap_busy)
    begin
      cap_cnt <= cap_cnt + 16'h0001;
      if (cap_cnt == cap_len)
        bus_discharged <= 1'b1;
      if (cap_cnt == cap_len + 16'h0008)
      begin
        cap_busy       <= 1'b0;
        power_off      <= 1'b0;
        bus_discharged <= 1'b0;
      end
    end
  end
endmodule

// file: pms_top_tb.sv
// self-checking testbench of the protection and maintenance block
`timescale 1ns/1ps
`include "pms_params.svh"
`define CHK(nm, ex, gt) \
  begin \
    num_checks++; \
    if ((gt) !== (ex)) \
    begin \
      mismatches++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module pms_top_tb;
  typedef struct {logic [5:0] word; logic [1:0] stress; logic inl; logic outl; logic fan; logic [8:0] exp;} pms_row_s;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        run_request = 1'b1;
  logic        trip_reset_pin = 1'b0;
  logic        clk_en = 1'b1;
  logic [1:0]  stress = 2'b00;
  logic        in_loss = 1'b0;
  logic        out_loss = 1'b0;
  logic        fan_locked = 1'b0;
  logic        cap_go = 1'b0;
  logic [15:0] cap_len = 16'h0064;
  logic        hs, ol, ipf, opf, fld, pwo, bdc;
  logic        motor_run, motor_coast, carrier_lower, overheat_status_output, life_warning, fan_run_cmd;
  logic        alarm_thermal, alarm_in_phase, alarm_out_phase, alarm_fan, irq;
  logic [31:0] rd;
  logic        er;
  int          mismatches = 0;
  int          num_checks = 0;
  pms_row_s    rows [10];
  logic [5:0]  cw [4] = '{6'h00, 6'h18, 6'h18, 6'h10};
  logic [31:0] cl [4] = '{32'h0000_0032, 32'h0000_0032, 32'h0000_00C8, 32'h0000_0032};
  logic        ce [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  wire  [8:0]  obs = {carrier_lower, alarm_thermal, alarm_in_phase, alarm_out_phase, alarm_fan,
                      motor_coast, overheat_status_output, life_warning, motor_run};

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  pms_top DUT (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .heatsink_overheat(hs), .overload_detect(ol), .input_phase_fault(ipf), .output_phase_fault(opf),
    .fan_lock_detect(fld), .power_off(pwo), .bus_discharged(bdc), .run_request(run_request),
    .trip_reset_pin(trip_reset_pin), .motor_run(motor_run), .motor_coast(motor_coast),
    .carrier_lower(carrier_lower), .overheat_status_output(overheat_status_output),
    .life_warning(life_warning), .fan_run_cmd(fan_run_cmd), .alarm_thermal(alarm_thermal),
    .alarm_in_phase(alarm_in_phase), .alarm_out_phase(alarm_out_phase), .alarm_fan(alarm_fan), .irq(irq));

  pms_plant plant (.ref_clk(ref_clk), .motor_run(motor_run), .fan_run_cmd(fan_run_cmd), .stress(stress),
    .in_loss(in_loss), .out_loss(out_loss), .fan_locked(fan_locked), .cap_go(cap_go), .cap_len(cap_len),
    .heatsink_overheat(hs), .overload_detect(ol), .input_phase_fault(ipf), .output_phase_fault(opf),
    .fan_lock_detect(fld), .power_off(pwo), .bus_discharged(bdc));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one apb transfer: setup, access held until pready is seen high
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr_en;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      mismatches++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(nm, ex, rd)
  endtask

  task automatic wr_word(input logic [5:0] w);
    wr(`PMS_OFS_WORD, {26'h000_0000, w});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    tick(6000);
    mismatches++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    rows = '{'{6'h00, 2'b01, 0, 0, 0, 9'h080}, '{6'h00, 2'b10, 0, 0, 0, 9'h080},
             '{6'h01, 2'b01, 0, 0, 0, 9'h101}, '{6'h01, 2'b10, 0, 0, 0, 9'h101},
             '{6'h00, 2'b00, 1, 0, 0, 9'h001}, '{6'h02, 2'b00, 1, 0, 0, 9'h040},
             '{6'h00, 2'b00, 0, 1, 0, 9'h001}, '{6'h04, 2'b00, 0, 1, 0, 9'h020},
             '{6'h00, 2'b00, 0, 0, 1, 9'h01E}, '{6'h20, 2'b00, 0, 0, 1, 9'h007}};
    tick(8);
    rst_b <= 1'b1;
    tick(2);
    // table of selection words against detection inputs
    foreach (rows[i])
    begin
      wr_word(rows[i].word);
      stress     <= rows[i].stress;
      in_loss    <= rows[i].inl;
      out_loss   <= rows[i].outl;
      fan_locked <= rows[i].fan;
      tick(10);
      `CHK("protection outputs", rows[i].exp, obs)
      {stress, in_loss, out_loss, fan_locked} <= 5'h00;
      tick(8);
      wr(`PMS_OFS_CMD, 32'h0000_0001);
    end
    // a trip outlives its cause until the reset pin clears it
    wr_word(6'h02);
    in_loss <= 1'b1;
    tick(10);
    in_loss <= 1'b0;
    tick(10);
    `CHK("latched trip", 2'b10, {alarm_in_phase, motor_run})
    rd_chk("status word", `PMS_OFS_STATUS, 32'h0000_0202);
    trip_reset_pin <= 1'b1;
    tick(2);
    trip_reset_pin <= 1'b0;
    tick(4);
    `CHK("cleared trip", 2'b01, {alarm_in_phase, motor_run})
    // interrupt masked, unmasked, cleared by reading
    apb(1'b0, `PMS_OFS_IRQ_STAT, 32'h0000_0000);
    wr(`PMS_OFS_IRQ_MASK, 32'h0000_0000);
    in_loss <= 1'b1;
    tick(10);
    `CHK("masked irq", 1'b0, irq)
    in_loss <= 1'b0;
    tick(8);
    wr(`PMS_OFS_CMD, 32'h0000_0001);
    wr(`PMS_OFS_IRQ_MASK, 32'h0000_0002);
    tick(2);
    `CHK("irq raised", 1'b1, irq)
    rd_chk("irq status", `PMS_OFS_IRQ_STAT, 32'h0000_0002);
    tick(2);
    `CHK("irq after read", 1'b0, irq)
    // fan under on/off control: stopped fan reads normal, start runs it and the lock raises the alarm and overheat status
    wr(`PMS_OFS_CFG, 32'h0000_0001);
    wr_word(6'h00);
    run_request <= 1'b0;
    fan_locked  <= 1'b1;
    tick(10);
    `CHK("fan stopped", 3'b000, {fan_run_cmd, alarm_fan, overheat_status_output})
    run_request <= 1'b1;
    tick(10);
    `CHK("fan started", 3'b111, {fan_run_cmd, alarm_fan, overheat_status_output})
    fan_locked <= 1'b0;
    tick(8);
    wr(`PMS_OFS_CMD, 32'h0000_0001);
    wr(`PMS_OFS_CFG, 32'h0000_0000);
    // capacitor life: disabled, user limit below and above, factory limit
    for (int k = 0; k < 4; k++)
    begin
      wr(`PMS_OFS_CAP_LIMIT, cl[k]);
      wr_word(cw[k]);
      cap_go <= 1'b1;
      tick(1);
      cap_go <= 1'b0;
      tick(130);
      `CHK("capacitor life", ce[k], life_warning)
      rd_chk("capacitor time", `PMS_OFS_CAP_MEAS, (k == 0) ? 32'h0000_0000 : {16'h0000, cap_len});
    end
    // reset in mid-run, then register reset values and access
    rst_b <= 1'b0;
    tick(2);
    `CHK("outputs in reset", 11'h000, {irq, fan_run_cmd, obs})
    rst_b <= 1'b1;
    tick(2);
    rd_chk("word reset", `PMS_OFS_WORD, 32'h0000_0000);
    rd_chk("mask reset", `PMS_OFS_IRQ_MASK, 32'h0000_0000);
    rd_chk("limit reset", `PMS_OFS_CAP_LIMIT, 32'h0000_0000);
    wr(`PMS_OFS_WORD, 32'hFFFF_FFFF);
    rd_chk("word width", `PMS_OFS_WORD, 32'h0000_003F);
    rd_chk("unmapped read", 8'h20, 32'h0000_0000);
    `CHK("unmapped error", 1'b1, er)
    // clock enable low freezes the pins and the trips
    clk_en  <= 1'b0;
    in_loss <= 1'b1;
    tick(10);
    `CHK("frozen trip", 2'b01, {alarm_in_phase, motor_run})
    clk_en <= 1'b1;
    tick(10);
    `CHK("trip after enable", 2'b10, {alarm_in_phase, motor_run})
    in_loss <= 1'b0;
    print_verdict();
  end
endmodule
